// >>> src/serializer_id_reset_lane_config.sv
`timescale 1ns/10ps
// Functional notes
// - Address bits 7:1 hold the 7-bit target address, strap default.
// - Second-port enable: port-1 address defaults to strap plus one.
// - Bit 0 picks address source: 0 strap pin, 1 programmed field.
// - Reset bit 3 holds DSI reset while 1; strapped, not self-clearing.
// - Writing 1 to reset bit 2 gives the DSI receiver a short pulse.
// - Reset bit 1 resets the core including registers, then clears.
// - Reset bit 0 resets the core, keeps registers except the strap fields (reloaded), then clears.
// - Lane bit 6 swaps port 1 clock lane P and N.
// - Lane bit 5 swaps port 1 data lanes P and N.
// - Lane bit 4 reverses port 1 lane order.
// - Lane bit 2 swaps port 0 clock lane P and N.
// - Lane bit 1 swaps port 0 data lanes P and N.
// - Lane bit 0 reverses port 0 lane order.
module serializer_id_reset_lane_config #(
    parameter int LANES = 4
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // straps; address and mode pins load on strap reload, address pin and second-port enable are also used every cycle
    input  wire logic [6:0]       addressStrapPin,
    input  wire logic             modeStrapPinOne,
    input  wire logic             secondPortBusEnable,
    // register port
    input  wire logic [7:0]       regAddr,
    input  wire logic [7:0]       regWriteData,
    input  wire logic             regWrite,
    output logic      [7:0]       regReadData,
    // address outputs
    output logic      [6:0]       targetAddress,
    output logic      [6:0]       port1TargetAddress,
    // reset outputs
    output logic                  dsiReset,
    output logic                  coreReset,
    // lane mapping outputs
    output logic                  port0ClockPolaritySwap,
    output logic                  port0DataPolaritySwap,
    output logic      [LANES-1:0] port0LaneSelect0,
    output logic                  port1ClockPolaritySwap,
    output logic                  port1DataPolaritySwap,
    output logic                  port0LaneOrderFlip,
    output logic                  port1LaneOrderFlip
);
    logic [6:0] targetAddressField;
    logic       addressSourceSelect;
    logic       dsiHold;
    logic [7:0] laneMapping;
    logic [7:0] generalConfig;
    logic [7:0] dsiCount;
    logic [7:0] coreCount;
    logic       coreRegsReset;
    logic       strapReload;
    logic       fullReset;
    logic       wrAddress;
    logic       wrReset;

    assign wrAddress   = regWrite
        && regAddr == serializer_regs_pkg::ADDR_BUS_ADDRESS;
    assign wrReset     = regWrite
        && regAddr == serializer_regs_pkg::ADDR_RESET_CONTROL;
    assign fullReset   = rst || coreRegsReset;
    assign strapReload = fullReset || (coreCount != 8'h00);

    // address register; strap fields reload on any core reset
    always_ff @(posedge clk_sys)
    begin
        if (strapReload)
        begin
            targetAddressField <= addressStrapPin;
        end
        else if (wrAddress)
        begin
            targetAddressField <= regWriteData[7:1];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (fullReset)
        begin
            addressSourceSelect <= 1'b0;
        end
        else if (wrAddress)
        begin
            addressSourceSelect <=
                regWriteData[serializer_regs_pkg::SOURCE_SELECT_BIT];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (fullReset)
        begin
            targetAddress      <= 7'h00;
            port1TargetAddress <= 7'h00;
        end
        else
        begin
            targetAddress <= addressSourceSelect ? targetAddressField
                                                 : addressStrapPin;
            if (addressSourceSelect)
            begin
                // field is assumed even so port 1 lands on field plus one
                port1TargetAddress <= targetAddressField + 7'h01;
            end
            else if (secondPortBusEnable)
            begin
                port1TargetAddress <= addressStrapPin + 7'h01;
            end
            else
            begin
                port1TargetAddress <= addressStrapPin;
            end
        end
    end

    // held DSI reset, strapped from the mode pin
    always_ff @(posedge clk_sys)
    begin
        if (strapReload)
        begin
            dsiHold <= modeStrapPinOne;
        end
        else if (wrReset)
        begin
            dsiHold <=
                regWriteData[serializer_regs_pkg::DSI_HOLD_BIT];
        end
    end

    // short DSI pulse counter
    always_ff @(posedge clk_sys)
    begin
        if (fullReset)
        begin
            dsiCount <= 8'h00;
        end
        else if (wrReset && regWriteData[serializer_regs_pkg::DSI_PULSE_BIT])
        begin
            dsiCount <= 8'(serializer_regs_pkg::DSI_PULSE_CYCLES);
        end
        else if (dsiCount != 8'h00)
        begin
            dsiCount <= dsiCount - 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dsiReset <= 1'b0;
        end
        else
        begin
            dsiReset <= dsiHold || (dsiCount != 8'h00);
        end
    end

    // core reset: register-clearing variant is a one-cycle internal pulse
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            coreRegsReset <= 1'b0;
        end
        else
        begin
            coreRegsReset <= wrReset
                && regWriteData[serializer_regs_pkg::CORE_REGS_BIT];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            coreCount <= 8'h00;
        end
        else if (wrReset && (regWriteData[serializer_regs_pkg::CORE_KEEP_BIT]
                 || regWriteData[serializer_regs_pkg::CORE_REGS_BIT]))
        begin
            coreCount <=
                8'(serializer_regs_pkg::CORE_PULSE_CYCLES);
        end
        else if (coreCount != 8'h00)
        begin
            coreCount <= coreCount - 8'h01;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            coreReset <= 1'b0;
        end
        else
        begin
            coreReset <= coreCount != 8'h00;
        end
    end

    // lane mapping and general config; kept across the keep-registers reset
    always_ff @(posedge clk_sys)
    begin
        if (fullReset)
        begin
            laneMapping   <= serializer_regs_pkg::LANE_MAPPING_RESET;
            generalConfig <= serializer_regs_pkg::GENERAL_CFG_RESET;
        end
        else if (regWrite)
        begin
            if (regAddr == serializer_regs_pkg::ADDR_LANE_MAPPING)
            begin
                laneMapping <= regWriteData
                    & serializer_regs_pkg::LANE_MAPPING_MASK;
            end
            if (regAddr == serializer_regs_pkg::ADDR_GENERAL_CFG)
            begin
                generalConfig <= regWriteData;
            end
        end
    end

    // lane 0 source per port-0 internal lane: one-hot pick of input lane
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++)
        begin : g_lane
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    port0LaneSelect0[lane] <= 1'b0;
                end
                else
                begin
                    port0LaneSelect0[lane] <= laneMapping[
                        serializer_regs_pkg::P0_FLIP_BIT]
                        ? (lane == LANES - 1) : (lane == 0);
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            port0ClockPolaritySwap <= 1'b0;
            port0DataPolaritySwap  <= 1'b0;
            port0LaneOrderFlip     <= 1'b0;
            port1ClockPolaritySwap <= 1'b0;
            port1DataPolaritySwap  <= 1'b0;
            port1LaneOrderFlip     <= 1'b0;
        end
        else
        begin
            port0ClockPolaritySwap <=
                laneMapping[serializer_regs_pkg::P0_CLK_SWAP_BIT];
            port0DataPolaritySwap  <=
                laneMapping[serializer_regs_pkg::P0_DATA_SWAP_BIT];
            port0LaneOrderFlip     <=
                laneMapping[serializer_regs_pkg::P0_FLIP_BIT];
            port1ClockPolaritySwap <=
                laneMapping[serializer_regs_pkg::P1_CLK_SWAP_BIT];
            port1DataPolaritySwap  <=
                laneMapping[serializer_regs_pkg::P1_DATA_SWAP_BIT];
            port1LaneOrderFlip     <=
                laneMapping[serializer_regs_pkg::P1_FLIP_BIT];
        end
    end

    // registered read path; self-clearing bits always read 0
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            regReadData <= 8'h00;
        end
        else
        begin
            unique case (regAddr)
                serializer_regs_pkg::ADDR_BUS_ADDRESS:
                    regReadData <= {targetAddressField, addressSourceSelect};
                serializer_regs_pkg::ADDR_RESET_CONTROL:
                    regReadData <= {4'h0, dsiHold, 3'h0};
                serializer_regs_pkg::ADDR_LANE_MAPPING:
                    regReadData <= laneMapping;
                serializer_regs_pkg::ADDR_GENERAL_CFG:
                    regReadData <= generalConfig;
                default:
                    regReadData <= 8'h00;
            endcase
        end
    end

    pulse_length_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrReset && regWriteData[2] && !dsiHold
        |=> ##1 dsiReset [*4] ##1 !dsiReset)
        else $error("dsi pulse length wrong");
    hold_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        dsiHold |=> dsiReset)
        else $error("dsi hold not applied");
    core_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrReset && regWriteData[0] |=> ##1 coreReset [*4] ##1 !coreReset)
        else $error("core reset pulse wrong");
    strap_reload_a: assert property (@(posedge clk_sys) disable iff (rst)
        coreCount != 8'h00 |=> targetAddressField == $past(addressStrapPin))
        else $error("strap not reloaded");
    regs_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        wrReset && regWriteData[1] |=> ##1 laneMapping == 8'h00)
        else $error("registers not cleared");
    reset_reads_a: assert property (@(posedge clk_sys) disable iff (rst)
        regAddr == 8'h01 |=> regReadData[2:0] == 3'h0)
        else $error("self-clearing bit read as one");
    source_select_a: assert property (@(posedge clk_sys) disable iff (rst)
        addressSourceSelect && !strapReload
        |=> targetAddress == $past(targetAddressField))
        else $error("programmed address not used");
    port1_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
        !addressSourceSelect && secondPortBusEnable && !fullReset
        |=> port1TargetAddress == $past(addressStrapPin) + 7'h01)
        else $error("port1 address not strap plus one");
    lane_swap_a: assert property (@(posedge clk_sys) disable iff (rst)
        laneMapping[6] && laneMapping[4] |=> port1ClockPolaritySwap
        && port1LaneOrderFlip)
        else $error("port1 mapping not applied");
endmodule

// >>> src/serializer_regs_pkg.sv
package serializer_regs_pkg;
    // register offsets on the control bus
    localparam logic [7:0] ADDR_BUS_ADDRESS   = 8'h00;
    localparam logic [7:0] ADDR_RESET_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_LANE_MAPPING  = 8'h02;
    localparam logic [7:0] ADDR_GENERAL_CFG   = 8'h03;
    // bus_address fields
    localparam int SOURCE_SELECT_BIT = 0;
    // reset_control fields
    localparam int DSI_HOLD_BIT      = 3;
    localparam int DSI_PULSE_BIT     = 2;
    localparam int CORE_REGS_BIT     = 1;
    localparam int CORE_KEEP_BIT     = 0;
    // lane_mapping_config fields
    localparam int P1_CLK_SWAP_BIT   = 6;
    localparam int P1_DATA_SWAP_BIT  = 5;
    localparam int P1_FLIP_BIT       = 4;
    localparam int P0_CLK_SWAP_BIT   = 2;
    localparam int P0_DATA_SWAP_BIT  = 1;
    localparam int P0_FLIP_BIT       = 0;
    localparam logic [7:0] LANE_MAPPING_MASK  = 8'h77;
    // reset values
    localparam logic [7:0] LANE_MAPPING_RESET = 8'h00;
    localparam logic [7:0] GENERAL_CFG_RESET  = 8'h92;
    // pulse widths
    localparam int  CLK_PERIOD_NS     = 25;
    localparam int  DSI_PULSE_NS      = 100;
    localparam int  DSI_PULSE_CYCLES  =
        (DSI_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int  CORE_PULSE_CYCLES = 4;
endpackage

// >>> tb/bus_host_model.sv
`timescale 1ns/10ps
module bus_host_model (
    // clock
    input  wire logic       clk_sys,
    // register port
    output logic      [7:0] regAddr,
    output logic      [7:0] regWriteData,
    output logic            regWrite,
    input  wire logic [7:0] regReadData
);
    initial
    begin
        regAddr      = 8'h00;
        regWriteData = 8'h00;
        regWrite     = 1'b0;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr      <= a;
        regWriteData <= d;
        regWrite     <= 1'b1;
        @(posedge clk_sys);
        regWrite     <= 1'b0;
        // released data must not keep showing the last byte
        regWriteData <= ~d;
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        d = regReadData;
    endtask
endmodule

// >>> tb/test_serializer_id_reset_lane_config.sv
`timescale 1ns/10ps
module test_serializer_id_reset_lane_config;
    logic       clk_sys             = 1'b0;
    logic       rst                 = 1'b1;
    logic [6:0] addressStrapPin     = 7'h2C;
    logic       modeStrapPinOne     = 1'b1;
    logic       secondPortBusEnable = 1'b1;
    logic [7:0] regAddr;
    logic [7:0] regWriteData;
    logic [7:0] regReadData;
    logic [7:0] rd;
    logic [7:0] e;
    logic       regWrite;
    logic [6:0] targetAddress;
    logic [6:0] port1TargetAddress;
    logic       dsiReset;
    logic       coreReset;
    logic       p0Clk, p0Data, p0Flip, p1Clk, p1Data, p1Flip;
    logic [3:0] p0Sel;
    int         n_errors = 0;
    int         n_tests  = 0;
    int         cycles   = 0;
    int         n;
    logic [7:0] laneIn  [8] = '{8'h01, 8'h02, 8'h04, 8'h10,
                                8'h20, 8'h40, 8'hFF, 8'h88};
    logic [7:0] laneExp [8] = '{8'h01, 8'h02, 8'h04, 8'h10,
                                8'h20, 8'h40, 8'h77, 8'h00};

    bus_host_model u_host (
        .clk_sys(clk_sys), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regReadData(regReadData)
    );

    serializer_id_reset_lane_config #(.LANES(4))
        u_serializer_id_reset_lane_config (
        .clk_sys(clk_sys), .rst(rst), .addressStrapPin(addressStrapPin),
        .modeStrapPinOne(modeStrapPinOne),
        .secondPortBusEnable(secondPortBusEnable),
        .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regReadData(regReadData),
        .targetAddress(targetAddress),
        .port1TargetAddress(port1TargetAddress),
        .dsiReset(dsiReset), .coreReset(coreReset),
        .port0ClockPolaritySwap(p0Clk), .port0DataPolaritySwap(p0Data),
        .port0LaneSelect0(p0Sel), .port1ClockPolaritySwap(p1Clk),
        .port1DataPolaritySwap(p1Data), .port0LaneOrderFlip(p0Flip),
        .port1LaneOrderFlip(p1Flip)
    );

    always #12.5 clk_sys = ~clk_sys;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // counts the cycles a reset output stands high after a write
    task automatic count_pulse(input bit core, output int cnt);
        cnt = 0;
        repeat (16)
        begin
            @(negedge clk_sys);
            cnt += core ? int'(coreReset === 1'b1) : int'(dsiReset === 1'b1);
        end
    endtask

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        u_host.read(8'h00, rd);
        check(rd, {7'h2C, 1'b0});
        check({1'b0, targetAddress}, 8'h2C);
        check({1'b0, port1TargetAddress}, 8'h2D);
        u_host.read(8'h01, rd);
        check(rd, 8'h08);
        check({7'h00, dsiReset}, 8'h01);
        u_host.read(8'h02, rd);
        check(rd, 8'h00);
        u_host.read(8'h03, rd);
        check(rd, 8'h92);
        u_host.write(8'h10, 8'h55);
        u_host.read(8'h10, rd);
        check(rd, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 8; i++)
        begin
            e = laneExp[i];
            u_host.write(8'h02, laneIn[i]);
            u_host.read(8'h02, rd);
            check(rd, e);
            check(8'(p1Clk), 8'(e[6]));
            check(8'(p1Data), 8'(e[5]));
            check(8'(p1Flip), 8'(e[4]));
            check(8'(p0Clk), 8'(e[2]));
            check(8'(p0Data), 8'(e[1]));
            check(8'(p0Flip), 8'(e[0]));
            check({4'h0, p0Sel}, e[0] ? 8'h08 : 8'h01);
        end
        $display("lane table done");
        u_host.write(8'h00, {7'h4A, 1'b1});
        u_host.read(8'h00, rd);
        check(rd, {7'h4A, 1'b1});
        check({1'b0, targetAddress}, 8'h4A);
        check({1'b0, port1TargetAddress}, 8'h4B);
        $display("programmed address done");
        u_host.write(8'h01, 8'h00);
        u_host.read(8'h01, rd);
        check({rd[7:1], dsiReset}, 8'h00);
        repeat (2)
        begin
            u_host.write(8'h01, 8'h04);
            count_pulse(1'b0, n);
            check(8'(n), 8'(serializer_regs_pkg::DSI_PULSE_CYCLES));
            u_host.read(8'h01, rd);
            check(rd, 8'h00);
        end
        $display("receiver reset done");
        u_host.write(8'h02, 8'h77);
        @(posedge clk_sys);
        addressStrapPin <= 7'h34;
        u_host.write(8'h01, 8'h01);
        count_pulse(1'b1, n);
        check(8'(n), 8'(serializer_regs_pkg::CORE_PULSE_CYCLES));
        u_host.read(8'h02, rd);
        check(rd, 8'h77);
        u_host.read(8'h00, rd);
        check({1'b0, rd[7:1]}, 8'h34);
        check({1'b0, targetAddress}, 8'h34);
        u_host.read(8'h01, rd);
        check(rd, 8'h08);
        check({7'h00, dsiReset}, 8'h01);
        $display("core reset keeping registers done");
        u_host.write(8'h03, 8'h00);
        u_host.write(8'h01, 8'h02);
        count_pulse(1'b1, n);
        check(8'(n), 8'(serializer_regs_pkg::CORE_PULSE_CYCLES));
        u_host.read(8'h02, rd);
        check(rd, 8'h00);
        u_host.read(8'h03, rd);
        check(rd, 8'h92);
        u_host.read(8'h00, rd);
        check(rd, {7'h34, 1'b0});
        u_host.read(8'h01, rd);
        check(rd, 8'h08);
        $display("core reset with registers done");
        // mid-run reset with new straps and the second port disabled
        u_host.write(8'h02, 8'h77);
        @(posedge clk_sys);
        addressStrapPin     <= 7'h11;
        modeStrapPinOne     <= 1'b0;
        secondPortBusEnable <= 1'b0;
        rst                 <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        u_host.read(8'h02, rd);
        check(rd, 8'h00);
        check({1'b0, targetAddress}, 8'h11);
        check({1'b0, port1TargetAddress}, 8'h11);
        u_host.read(8'h00, rd);
        check(rd, {7'h11, 1'b0});
        u_host.read(8'h01, rd);
        check({rd[7:1], dsiReset}, 8'h00);
        u_host.write(8'h01, 8'h08);
        u_host.read(8'h01, rd);
        check(rd, 8'h08);
        check({7'h00, dsiReset}, 8'h01);
        @(posedge clk_sys);
        secondPortBusEnable <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check({1'b0, port1TargetAddress}, 8'h12);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule
